//--- rtl/bts_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Pointers wrap naturally at DEPTH
`timescale 1ns/1ps
`default_nettype none
module bts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,  // System clock
  input wire logic resetn,    // Async reset, active low
  bts_stream_if.snk in_s,     // Fill side
  bts_stream_if.src out_s     // Drain side
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } bts_fifo_type;

  bts_fifo_type q, n;
  logic         put, take;

  assign in_s.ready  = (q.cnt != FULL);
  assign out_s.valid = (q.cnt != '0);
  assign out_s.data  = q.mem[q.rd];
  assign put         = in_s.valid && in_s.ready;
  assign take        = out_s.valid && out_s.ready;

  always_comb begin
    n = q;
    if (put) begin
      n.mem[q.wr] = in_s.data;
      n.wr        = q.wr + 1'b1;
    end
    if (take) begin
      n.rd = q.rd + 1'b1;
    end
    if (put && !take) begin
      n.cnt = q.cnt + 1'b1;
    end else if (take && !put) begin
      n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

//--- rtl/bts_framer.sv
// Purpose: Builds charge and temperature telemetry sentences as ASCII
// Assumes: Query decoder, cell data and temp store share core_clk
// Notes:   Checksum is an 8-bit sum of all bytes before it
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"

// Operation
// - Charge and both summaries sent periodically, separate active and sleep periods.
// - A query for any sentence kind is answered with that sentence.
// - Module temperature detail sentences go out only after a query.
// - Without cell link, affected sentences carry only commas and checksum.
// - Cell temperature summary is empty when no external sensor is fitted.
// - Charge field one is pack charge in coulombs, unsigned hex.
// - Charge field two is pack capacity in coulombs, unsigned hex.
// - Charge field three is state of charge, signed hex, 0.01 percent.
// - Summary field one is detected cell count, unsigned hex.
// - Module summary fields two to four: min, max, average temperature.
// - Cell summary fields two to four: min, max, average temperature.
// - Fifth summary field is always sent empty.
// - Detail answer splits into groups of one to eight cells.
// - Detail field one is string index, zero for a single string.
// - Detail field two is first cell index, counted across strings; three is size.
// - Detail field four is one hex byte per cell temperature.
module bts_framer
  import bts_pkg::*;
#(
  parameter logic [15:0] MS_CYCLES = 16'(`BTS_MS_CYCLES)
) (
  input  wire logic          core_clk,          // System clock, 50 MHz
  input  wire logic          resetn,            // Async reset, active low
  input  wire logic          sleep_mode,        // High selects sleep period
  input  wire logic [15:0]   active_period_ms,  // Period when active, 0 = off
  input  wire logic [15:0]   sleep_period_ms,   // Period when asleep, 0 = off
  input  wire logic          query_valid,       // Decoded query pulse
  input  wire bts_kind_type  query_kind,        // Sentence asked for
  input  wire logic          cell_link_ok,      // Cell modules answering
  input  wire logic          ext_sensor_fitted, // Any external cell sensor
  input  wire logic [31:0]   charge_c,          // Pack charge, coulombs
  input  wire logic [31:0]   capacity_c,        // Pack capacity, coulombs
  input  wire logic [15:0]   soc_centi,         // State of charge, 0.01 %
  input  wire logic [15:0]   cell_count,        // Cells detected
  input  wire logic [15:0]   cells_per_string,  // 0 = single string
  input  wire logic [7:0]    mod_t_min,         // Module temps, +100 offset
  input  wire logic [7:0]    mod_t_max,         // Module temp max
  input  wire logic [7:0]    mod_t_avg,         // Module temp average
  input  wire logic [7:0]    cell_t_min,        // Cell temps, +100 offset
  input  wire logic [7:0]    cell_t_max,        // Cell temp max
  input  wire logic [7:0]    cell_t_avg,        // Cell temp average
  output logic      [15:0]   temp_addr,         // Cell index into temp store
  input  wire logic [7:0]    temp_data,         // Module temp at temp_addr
  output logic      [7:0]    tx_data,           // Sentence byte
  output logic               tx_valid,          // Byte available
  input  wire logic          tx_ready           // Serialiser takes byte
);
  typedef struct packed {
    bts_state_type st;
    bts_kind_type  kind;
    logic [2:0]    fld;
    logic [2:0]    dig;
    logic [31:0]   val;
    logic [7:0]    ck;
    logic [1:0]    idc;
    logic          emp;
    logic [3:0]    pend;
    logic [15:0]   pre;
    logic [15:0]   ms;
    logic [15:0]   first;
    logic [7:0]    strn;
    logic [15:0]   sleft;
    logic [3:0]    gsz;
    logic [3:0]    k;
    logic [15:0]   addr;
    logic [7:0]    tdat;
    logic [7:0]    txd;
    logic          txv;
  } bts_frm_type;

  bts_frm_type q, n;
  bts_stream_if #(.WIDTH(8)) fi ();
  bts_stream_if #(.WIDTH(8)) fo ();

  logic        emit;
  logic [7:0]  ch;
  logic        push;
  logic [15:0] period;
  logic [15:0] cps;
  logic [31:0] fval;
  logic [2:0]  fnd;
  logic [2:0]  nf;
  logic [15:0] nfirst;
  logic [15:0] nsleft;

  function automatic logic [7:0] hexc(input logic [3:0] v);
    if (v < 4'ha) begin
      return `BTS_CH_DIGIT + {4'h0, v};
    end
    return `BTS_CH_ALPHA + {4'h0, v};
  endfunction

  // Group never crosses a string end or the last cell
  function automatic logic [3:0] grp(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] m;
    m = (a < b) ? a : b;
    if (m > `BTS_GROUP_MAX) begin
      m = `BTS_GROUP_MAX;
    end
    return m[3:0];
  endfunction

  function automatic logic [23:0] ident(input bts_kind_type kd);
    case (kd)
      K_CHARGE: return `BTS_ID_CHARGE;
      K_MT_SUM: return `BTS_ID_MT_SUM;
      K_MT_DET: return `BTS_ID_MT_DET;
      default:  return `BTS_ID_CT_SUM;
    endcase
  endfunction

  bts_fifo #(.WIDTH(8), .DEPTH(`BTS_FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .in_s     (fi.snk),
    .out_s    (fo.src)
  );

  assign fi.valid = emit;
  assign fi.data  = ch;
  assign push     = emit && fi.ready;
  assign fo.ready = !q.txv || tx_ready;
  assign period   = sleep_mode ? sleep_period_ms : active_period_ms;
  assign cps      = (cells_per_string == 16'h0000) ? cell_count : cells_per_string;

  // Field contents per kind and index
  always_comb begin
    fval = 32'h0;
    fnd  = `BTS_ND_BYTE;
    nf   = `BTS_NF_SUM;
    case (q.kind)
      K_CHARGE: begin
        nf = `BTS_NF_CHARGE;
        case (q.fld)
          3'h0: begin fval = charge_c; fnd = `BTS_ND_COUL; end
          3'h1: begin fval = capacity_c; fnd = `BTS_ND_COUL; end
          default: begin fval = {16'h0, soc_centi}; fnd = `BTS_ND_SOC; end
        endcase
      end
      K_MT_DET: begin
        nf = `BTS_NF_DET;
        case (q.fld)
          3'h0: fval = {24'h0, q.strn};
          3'h1: begin fval = {16'h0, q.first}; fnd = `BTS_ND_COUNT; end
          default: fval = {28'h0, q.gsz};
        endcase
      end
      default: begin
        case (q.fld)
          3'h0: begin fval = {16'h0, cell_count}; fnd = `BTS_ND_COUNT; end
          3'h1: fval = {24'h0, (q.kind == K_MT_SUM) ? mod_t_min : cell_t_min};
          3'h2: fval = {24'h0, (q.kind == K_MT_SUM) ? mod_t_max : cell_t_max};
          default: fval = {24'h0, (q.kind == K_MT_SUM) ? mod_t_avg : cell_t_avg};
        endcase
      end
    endcase
  end

  always_comb begin
    n      = q;
    emit   = 1'b0;
    ch     = `BTS_CH_COMMA;
    nfirst = q.first + {12'h0, q.gsz};
    nsleft = q.sleft - {12'h0, q.gsz};
    case (q.st)
      S_IDLE: begin
        if (q.pend != 4'h0) begin
          if (q.pend[K_CHARGE]) begin
            n.kind = K_CHARGE;
          end else if (q.pend[K_MT_SUM]) begin
            n.kind = K_MT_SUM;
          end else if (q.pend[K_CT_SUM]) begin
            n.kind = K_CT_SUM;
          end else begin
            n.kind = K_MT_DET;
          end
          n.pend[n.kind] = 1'b0;
          n.st  = S_ID;
          n.idc = 2'h0;
          n.fld = 3'h0;
          n.ck  = `BTS_CK_SEED;
          case (n.kind)
            K_CHARGE: n.emp = 1'b0;
            K_CT_SUM: n.emp = !cell_link_ok || !ext_sensor_fitted;
            K_MT_DET: n.emp = !cell_link_ok || (cell_count == 16'h0000);
            default:  n.emp = !cell_link_ok;
          endcase
          n.first = 16'h0000;
          n.strn  = 8'h00;
          n.sleft = cps;
          n.gsz   = grp(cps, cell_count);
        end
      end
      S_ID: begin
        emit = 1'b1;
        ch   = 8'(ident(q.kind) >> {3'h2 - q.idc, 3'h0});
        if (push) begin
          n.ck  = q.ck + ch;
          n.idc = q.idc + 2'h1;
          if (q.idc == 2'h2) begin
            n.st = S_COMMA;
          end
        end
      end
      S_COMMA: begin
        emit = 1'b1;
        if (push) begin
          n.ck = q.ck + ch;
          if (q.fld == nf) begin
            n.st = S_CK_HI;
          end else if (q.emp || (q.kind != K_CHARGE && q.kind != K_MT_DET
                                 && q.fld == `BTS_FLD_SPARE)) begin
            n.fld = q.fld + 3'h1;
          end else if (q.kind == K_MT_DET && q.fld == `BTS_FLD_ARRAY) begin
            n.k  = 4'h0;
            n.st = S_A_ADDR;
          end else begin
            n.val = fval;
            n.dig = fnd;
            n.st  = S_HEX;
          end
        end
      end
      S_HEX: begin
        emit = 1'b1;
        ch   = hexc(4'(q.val >> {q.dig, 2'b00}));
        if (push) begin
          n.ck = q.ck + ch;
          if (q.dig == 3'h0) begin
            n.fld = q.fld + 3'h1;
            n.st  = S_COMMA;
          end else begin
            n.dig = q.dig - 3'h1;
          end
        end
      end
      S_A_ADDR: begin
        n.addr = q.first + {12'h0, q.k};
        n.st   = S_A_HI;
      end
      S_A_HI: begin
        emit = 1'b1;
        ch   = hexc(temp_data[7:4]);
        if (push) begin
          n.ck   = q.ck + ch;
          n.tdat = temp_data;
          n.st   = S_A_LO;
        end
      end
      S_A_LO: begin
        emit = 1'b1;
        ch   = hexc(q.tdat[3:0]);
        if (push) begin
          n.ck = q.ck + ch;
          if (q.k == q.gsz - 4'h1) begin
            n.fld = q.fld + 3'h1;
            n.st  = S_COMMA;
          end else begin
            n.k  = q.k + 4'h1;
            n.st = S_A_ADDR;
          end
        end
      end
      S_CK_HI: begin
        emit = 1'b1;
        ch   = hexc(q.ck[7:4]);
        if (push) begin
          n.st = S_CK_LO;
        end
      end
      S_CK_LO: begin
        emit = 1'b1;
        ch   = hexc(q.ck[3:0]);
        if (push) begin
          n.st = S_CR;
        end
      end
      S_CR: begin
        emit = 1'b1;
        ch   = `BTS_CH_CR;
        if (push) begin
          n.st = S_LF;
        end
      end
      S_LF: begin
        emit = 1'b1;
        ch   = `BTS_CH_LF;
        if (push) begin
          n.st = S_IDLE;
          // Next group of the same detail answer
          if (q.kind == K_MT_DET && !q.emp && nfirst < cell_count) begin
            n.first = nfirst;
            n.sleft = (nsleft == 16'h0000) ? cps : nsleft;
            n.strn  = (nsleft == 16'h0000) ? q.strn + 8'h01 : q.strn;
            n.gsz   = grp(n.sleft, cell_count - nfirst);
            n.idc   = 2'h0;
            n.fld   = 3'h0;
            n.ck    = `BTS_CK_SEED;
            n.st    = S_ID;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase

    // Requests come after the clear above, so a same-cycle request is kept
    if (q.pre >= MS_CYCLES - 16'h0001) begin
      n.pre = 16'h0000;
      if (period != 16'h0000 && q.ms >= period - 16'h0001) begin
        n.ms             = 16'h0000;
        n.pend[K_CHARGE] = 1'b1;
        n.pend[K_MT_SUM] = 1'b1;
        n.pend[K_CT_SUM] = 1'b1;
      end else begin
        n.ms = (period == 16'h0000) ? 16'h0000 : q.ms + 16'h0001;
      end
    end else begin
      n.pre = q.pre + 16'h0001;
    end
    if (query_valid) begin
      n.pend[query_kind] = 1'b1;
    end

    // Output stage keeps tx outputs on flops
    if (fo.ready) begin
      n.txv = fo.valid;
      n.txd = fo.data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign temp_addr = q.addr;
  assign tx_data   = q.txd;
  assign tx_valid  = q.txv;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_DET_BY_QUERY: assert property ($rose(q.pend[K_MT_DET]) |->
    $past(query_valid) && $past(query_kind) == K_MT_DET)
    else $error("detail pending without a query");
  AST_QUERY_KEPT: assert property (query_valid |=> q.pend[$past(query_kind)])
    else $error("query lost");
  AST_PERIOD_SETS: assert property ((q.pre >= MS_CYCLES - 16'h0001
    && period != 16'h0000 && q.ms >= period - 16'h0001)
    |=> q.pend[K_CHARGE] && q.pend[K_MT_SUM] && q.pend[K_CT_SUM])
    else $error("period expiry did not queue sentences");
  AST_EMPTY_NO_HEX: assert property (q.emp |-> q.st != S_HEX && q.st != S_A_HI)
    else $error("data digits in an empty sentence");
  AST_NO_SENSOR: assert property ((q.st == S_IDLE && n.st == S_ID
    && n.kind == K_CT_SUM && !ext_sensor_fitted) |=> q.emp)
    else $error("cell summary not empty without sensors");
  AST_SPARE_EMPTY: assert property ((q.kind == K_MT_SUM || q.kind == K_CT_SUM)
    |-> !(q.st == S_HEX && q.fld == `BTS_FLD_SPARE))
    else $error("fifth summary field not empty");
  AST_GROUP_SIZE: assert property ((q.kind == K_MT_DET && q.st == S_A_LO)
    |-> q.gsz >= 4'h1 && q.gsz <= 4'h8)
    else $error("group size out of range");
  AST_HEX_UPPER: assert property ((push && q.st == S_HEX) |->
    ((ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h41 && ch <= 8'h46)))
    else $error("hex digit not uppercase");
  AST_SOC_WIDTH: assert property ((push && q.st == S_COMMA && !q.emp
    && q.kind == K_CHARGE && q.fld == 3'h2) |=> q.st == S_HEX && q.dig == 3'h3)
    else $error("state of charge width wrong");
  AST_CK_AFTER: assert property ((push && q.st == S_CK_LO) |=>
    q.st == S_CR ##1 (q.st == S_CR || q.st == S_LF))
    else $error("line end does not follow checksum");
endmodule
`default_nettype wire

//--- shared/bts_defs.svh
// Purpose: Constants for the telemetry sentence framer
// Assumes: 50 MHz core clock
// Notes:   Field widths are given as hex digit count minus one
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH
`define BTS_CLK_NS      20
`define BTS_MS_NS       1000000
`define BTS_MS_CYCLES   (`BTS_MS_NS / `BTS_CLK_NS)
`define BTS_ID_CHARGE   24'h424331
`define BTS_ID_MT_SUM   24'h425431
`define BTS_ID_MT_DET   24'h425432
`define BTS_ID_CT_SUM   24'h425433
`define BTS_CH_COMMA    8'h2c
`define BTS_CH_CR       8'h0d
`define BTS_CH_LF       8'h0a
`define BTS_CH_DIGIT    8'h30
`define BTS_CH_ALPHA    8'h37
`define BTS_CK_SEED     8'h00
`define BTS_ND_COUL     3'h7
`define BTS_ND_SOC      3'h3
`define BTS_ND_COUNT    3'h3
`define BTS_ND_BYTE     3'h1
`define BTS_NF_CHARGE   3'h3
`define BTS_NF_SUM      3'h5
`define BTS_NF_DET      3'h4
`define BTS_FLD_SPARE   3'h4
`define BTS_FLD_ARRAY   3'h3
`define BTS_GROUP_MAX   16'h0008
`define BTS_FIFO_DEPTH  16
`endif

//--- shared/bts_pkg.sv
// Purpose: Types shared by the sentence framer
// Assumes: Nothing
// Notes:   Kind codes double as pending-bit indices
package bts_pkg;
  typedef enum logic [1:0] {
    K_CHARGE = 2'b00,
    K_MT_SUM = 2'b01,
    K_MT_DET = 2'b10,
    K_CT_SUM = 2'b11
  } bts_kind_type;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_ID     = 4'b0001,
    S_COMMA  = 4'b0010,
    S_HEX    = 4'b0011,
    S_A_ADDR = 4'b0100,
    S_A_HI   = 4'b0101,
    S_A_LO   = 4'b0110,
    S_CK_HI  = 4'b0111,
    S_CK_LO  = 4'b1000,
    S_CR     = 4'b1001,
    S_LF     = 4'b1010
  } bts_state_type;
endpackage

//--- shared/bts_stream_if.sv
// Purpose: Valid/ready byte stream between framer and FIFO
// Assumes: Single clock
// Notes:   Data is held while valid waits for ready
`timescale 1ns/1ps
`default_nettype none
interface bts_stream_if #(parameter int WIDTH = 8) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- testbench/bts_link_model.sv
// Purpose: Far side of the framer: serial byte sink and cell temp store
// Assumes: A byte is taken on a core_clk rise with tx_valid and tx_ready high
// Notes:   Slow mode drops ready every other cycle so the FIFO backs up
`timescale 1ns/1ps
`default_nettype none
module bts_link_model (
  input  wire logic        core_clk,  // System clock
  input  wire logic        resetn,    // Async reset, active low
  input  wire logic        slow,      // Stall every other cycle
  input  wire logic [7:0]  tx_data,   // Sentence byte
  input  wire logic        tx_valid,  // Byte available
  output logic             tx_ready,  // Byte taken
  input  wire logic [15:0] temp_addr, // Cell index
  output logic      [7:0]  temp_data  // Module temp, +100 offset
);
  logic [7:0] rx_q [$];

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
      end
      tx_ready <= slow ? !tx_ready : 1'b1;
    end
  end

  // Distinct value per cell so a wrong address shows up
  assign temp_data = 8'h60 + temp_addr[7:0];
endmodule
`default_nettype wire

//--- testbench/test_battery_charge_temperature_sentences.sv
// Purpose: Self-checking bench for the telemetry sentence framer
// Assumes: Short millisecond prescaler of 10 cycles
// Notes:   Expected sentences, checksum included, are rebuilt here from inputs
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"
module test_battery_charge_temperature_sentences;
  import bts_pkg::*;
  logic         core_clk = 0, resetn = 0, sleep_mode = 0, query_valid = 0;
  logic         cell_link_ok = 1, ext_sensor_fitted = 1, slow = 0, tx_ready, tx_valid;
  bts_kind_type query_kind = K_CHARGE;
  logic [15:0]  active_period_ms = 0, sleep_period_ms = 0, soc_centi = 0;
  logic [15:0]  cell_count = 16'h0050, cells_per_string = 0, temp_addr;
  logic [31:0]  charge_c = 0, capacity_c = 0;
  logic [7:0]   mod_t_min = 8'h78, mod_t_max = 8'h7a, mod_t_avg = 8'h78;
  logic [7:0]   cell_t_min = 8'h7a, cell_t_max = 8'h7b, cell_t_avg = 8'h7a;
  logic [7:0]   temp_data, tx_data;
  int           n_errors = 0, checks_done = 0;

  always #10 core_clk = ~core_clk;

  bts_framer #(.MS_CYCLES(16'h000a)) DUT (.core_clk(core_clk), .resetn(resetn),
    .sleep_mode(sleep_mode), .active_period_ms(active_period_ms),
    .sleep_period_ms(sleep_period_ms), .query_valid(query_valid), .query_kind(query_kind),
    .cell_link_ok(cell_link_ok), .ext_sensor_fitted(ext_sensor_fitted), .charge_c(charge_c),
    .capacity_c(capacity_c), .soc_centi(soc_centi), .cell_count(cell_count),
    .cells_per_string(cells_per_string), .mod_t_min(mod_t_min), .mod_t_max(mod_t_max),
    .mod_t_avg(mod_t_avg), .cell_t_min(cell_t_min), .cell_t_max(cell_t_max),
    .cell_t_avg(cell_t_avg), .temp_addr(temp_addr), .temp_data(temp_data),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  bts_link_model SINK (.core_clk(core_clk), .resetn(resetn), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .temp_addr(temp_addr), .temp_data(temp_data));

  function automatic string h(logic [31:0] v, int n);
    string s;
    logic [7:0] c;
    s = "";
    for (int i = n - 1; i >= 0; i--) begin
      c = (v[4*i +: 4] < 4'ha) ? 8'h30 + v[4*i +: 4] : 8'h37 + v[4*i +: 4];
      s = {s, $sformatf("%c", c)};
    end
    return s;
  endfunction

  // Sum runs over every byte up to the comma before the checksum
  function automatic string seal(string b);
    logic [7:0] ck;
    b = {b, ","};
    ck = 8'h00;
    foreach (b[i]) ck = ck + b[i];
    return {b, h(ck, 2), "\r\n"};
  endfunction

  // Identifier characters come from the shared codes
  function automatic string ids(logic [23:0] v);
    return $sformatf("%c%c%c", v[23:16], v[15:8], v[7:0]);
  endfunction

  function automatic string summ(logic m);
    return seal({ids(m ? `BTS_ID_MT_SUM : `BTS_ID_CT_SUM), ",", h(cell_count, 4), ",",
      h(m ? mod_t_min : cell_t_min, 2), ",", h(m ? mod_t_max : cell_t_max, 2), ",",
      h(m ? mod_t_avg : cell_t_avg, 2), ","});
  endfunction

  function automatic string chg();
    return seal({ids(`BTS_ID_CHARGE), ",", h(charge_c, 8), ",", h(capacity_c, 8), ",",
      h(soc_centi, 4)});
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic query(bts_kind_type k);
    @(negedge core_clk);
    query_valid = 1'b1;
    query_kind = k;
    @(negedge core_clk);
    query_valid = 1'b0;
  endtask

  // Waits for a whole sentence, then compares it byte by byte
  task automatic take(string name, string e);
    int t;
    logic [7:0] c;
    t = 0;
    while (SINK.rx_q.size() < e.len() && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    checks_done++;
    for (int i = 0; i < e.len(); i++) begin
      c = (SINK.rx_q.size() > 0) ? SINK.rx_q.pop_front() : 8'h00;
      if (c !== e[i]) begin
        n_errors++;
        $display("[ERR] %s byte %0d expected %h seen %h", name, i, e[i], c);
        SINK.rx_q.delete();
        break;
      end
    end
  endtask

  task automatic quiet(string name, int cycles);
    repeat (cycles) @(posedge core_clk);
    checks_done++;
    if (SINK.rx_q.size() != 0) begin
      n_errors++;
      $display("[ERR] %s expected 0 bytes seen %0d", name, SINK.rx_q.size());
      SINK.rx_q.delete();
    end
  endtask

  // The unused period is short, so obeying it would send early
  task automatic t_periodic(logic sl);
    @(negedge core_clk);
    sleep_mode = sl;
    active_period_ms = sl ? 16'h0005 : 16'h0014;
    sleep_period_ms = sl ? 16'h0014 : 16'h0005;
    quiet("early periodic", 120);
    take("periodic charge", chg());
    take("periodic module summary", summ(1'b1));
    take("periodic cell summary", summ(1'b0));
    @(negedge core_clk);
    active_period_ms = 16'h0000;
    sleep_period_ms = 16'h0000;
    quiet("no spontaneous detail", 400);
  endtask

  task automatic t_charge();
    @(negedge core_clk);
    charge_c = 32'h000456f0;
    capacity_c = 32'h00057e40;
    soc_centi = 16'hfe0c;
    query(K_CHARGE);
    take("charge", chg());
  endtask

  task automatic t_summaries();
    query(K_MT_SUM);
    take("module summary", summ(1'b1));
    query(K_CT_SUM);
    take("cell summary", summ(1'b0));
    @(negedge core_clk);
    ext_sensor_fitted = 1'b0;
    query(K_CT_SUM);
    take("cell summary no sensor", seal({ids(`BTS_ID_CT_SUM), ",,,,,"}));
    @(negedge core_clk);
    ext_sensor_fitted = 1'b1;
    cell_link_ok = 1'b0;
    query(K_MT_SUM);
    take("module summary no link", seal({ids(`BTS_ID_MT_SUM), ",,,,,"}));
    query(K_CT_SUM);
    take("cell summary no link", seal({ids(`BTS_ID_CT_SUM), ",,,,,"}));
    query(K_MT_DET);
    take("detail no link", seal({ids(`BTS_ID_MT_DET), ",,,,"}));
    @(negedge core_clk);
    cell_link_ok = 1'b1;
    cell_count = 16'h0000;
    query(K_MT_DET);
    take("detail no cells", seal({ids(`BTS_ID_MT_DET), ",,,,"}));
    @(negedge core_clk);
    cell_count = 16'h0050;
  endtask

  task automatic t_detail(logic [15:0] count, logic [15:0] cps, logic sl);
    int first, slen, size;
    string a, e;
    @(negedge core_clk);
    cell_count = count;
    cells_per_string = cps;
    slow = sl;
    query(K_MT_DET);
    slen = (cps == 0) ? count : cps;
    first = 0;
    while (first < count) begin
      size = (first / slen + 1) * slen - first;
      if (size > 8) size = 8;
      // Last group is cut short by the cell count, not only by the string
      if (size > int'(count) - first) size = int'(count) - first;
      a = "";
      for (int i = first; i < first + size; i++) a = {a, h(8'h60 + i, 2)};
      e = {ids(`BTS_ID_MT_DET), ",", h(first / slen, 2), ",", h(first, 4), ",", h(size, 2)};
      take("detail", seal({e, ",", a}));
      first += size;
    end
    @(negedge core_clk);
    slow = 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    conclude();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    t_periodic(1'b0);
    t_periodic(1'b1);
    t_charge();
    t_summaries();
    t_detail(16'h000a, 16'h0000, 1'b0);
    t_detail(16'h000a, 16'h0003, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
